// file: hw/ces_core.sv
// error status, error counters and receive buffer count of the can controller
`timescale 1ns/1ns
module ces_core
  import ces_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // cpu sfr access
  input wire ces_sfr_req_t SFR_REQ_I,
  output logic [7:0] SFR_RDATA_O,
  // events from the protocol machine
  input wire ces_evt_t EVT_I,
  // error interrupt and reactions to the protocol machine
  output logic ERR_INT_O,
  output logic TX_KEEP_REQ_O,
  output logic RX_FLAGS_BLOCK_O,
  output logic RX_DISCARD_O,
  output logic PM_RESET_O,
  // receive buffer configuration
  output logic [1:0] BASE_SEL_O,
  output logic [4:0] BUF_COUNT_O
);

  // whole block state in one struct; next_st is its combinational copy
  ces_state_t st;
  ces_state_t next_st;

  // legal buffer count for a written field; zero keeps the old count
  // a refused zero never clears a set count; after reset the count stays zero until a legal write
  function automatic logic [4:0] fix_count(input logic [4:0] wr, input logic [4:0] old);
    logic [4:0] res;
    res = wr;
    if (wr[BIT_CNT_TOP])
    begin
      res = BUF_COUNT_MAX;
    end
    else if (wr == BUF_COUNT_ZERO)
    begin
      res = old;
    end
    return res;
  endfunction : fix_count

  // saturating counter step
  // an increment beats a decrement arriving in the same cycle
  function automatic logic [7:0] cnt_step(input logic [7:0] cnt, input logic up,
                                          input logic [7:0] amt, input logic down);
    logic [8:0] sum;
    logic [7:0] res;
    sum = {1'b0, cnt} + {1'b0, amt};
    res = cnt;
    if (up)
    begin
      res = sum[8] ? ERR_SAT : sum[7:0];
    end
    else if (down && (cnt != RST_ERR_CNT))
    begin
      res = cnt - ERR_STEP_ONE;
    end
    return res;
  endfunction : cnt_step

  logic wr_status;
  logic wr_bufcnt;
  logic [7:0] status_view;

  // address decode of the writes
  // a read beside a write in one cycle still returns the old value
  assign wr_status = SFR_REQ_I.wr && (SFR_REQ_I.addr == ADDR_ERR_STATUS);
  assign wr_bufcnt = SFR_REQ_I.wr && (SFR_REQ_I.addr == ADDR_BUF_COUNT);

  // live status byte; bit 4 reads zero
  // bus-off and init state are live inputs and are not stored here
  always_comb
  begin
    status_view = RST_ERR_STATUS;
    status_view[BIT_BOFF] = EVT_I.bus_off;
    status_view[BIT_RECS] = (st.rx_error_count >= ERR_WARN_LEVEL);
    status_view[BIT_TECS] = (st.tx_error_count >= ERR_WARN_LEVEL);
    status_view[BIT_INIT_STATE] = EVT_I.init_state;
    status_view[BIT_VALID] = st.valid;
    status_view[BIT_WAKE] = st.wake;
    status_view[BIT_OVER] = st.over;
  end

  // next state of the whole block
  always_comb
  begin
    logic set_wake;
    logic set_over;
    logic set_valid;
    logic hold_clr;
    logic [7:0] wd;
    set_wake = (EVT_I.sleep_state && EVT_I.bus_activity)
            || (EVT_I.sleep_req && EVT_I.rx_tx_busy);
    set_over = EVT_I.tx_fetch_miss || EVT_I.rx_store_miss || EVT_I.id_fetch_miss;
    set_valid = EVT_I.valid_frame;
    hold_clr = EVT_I.init_req;
    wd = SFR_REQ_I.wdata;
    next_st = st;
    // sticky flags: write one clears, zero ignored, set beats clear
    // clears go first so that a set in the same cycle overrides them
    if ((wr_status && wd[BIT_VALID]) || hold_clr)
    begin
      next_st.valid = 1'b0;
    end
    if ((wr_status && wd[BIT_WAKE]) || hold_clr)
    begin
      next_st.wake = 1'b0;
    end
    if ((wr_status && wd[BIT_OVER]) || hold_clr)
    begin
      next_st.over = 1'b0;
    end
    if (set_valid)
    begin
      next_st.valid = 1'b1;
    end
    if (set_wake)
    begin
      next_st.wake = 1'b1;
    end
    if (set_over)
    begin
      next_st.over = 1'b1;
    end
    // interrupt held while resume or overrun flag stands
    next_st.err_int = next_st.wake || next_st.over;
    // reactions to ram access misses, one-cycle pulses
    // the protocol machine acts on them; only the overrun flag is remembered here
    next_st.tx_keep_req = EVT_I.tx_fetch_miss;
    next_st.rx_flags_block = EVT_I.rx_store_miss;
    next_st.rx_discard = EVT_I.id_fetch_miss;
    // error counters, step sizes of the can fault confinement
    next_st.tx_error_count = cnt_step(st.tx_error_count, EVT_I.tx_err, ERR_STEP_BIG, EVT_I.tx_ok);
    next_st.rx_error_count = cnt_step(st.rx_error_count, EVT_I.rx_err || EVT_I.rx_err_primary,
                           EVT_I.rx_err_primary ? ERR_STEP_BIG : ERR_STEP_ONE,
                           EVT_I.rx_ok);
    // a good frame while error passive drops the count back into range
    if (EVT_I.rx_ok && (st.rx_error_count > REC_PASSIVE_TOP))
    begin
      next_st.rx_error_count = REC_PASSIVE_TOP;
    end
    // protocol reset only honoured while bus-off
    // a stray write outside bus-off must not disturb live traffic
    next_st.pm_reset = wr_bufcnt && wd[BIT_PM_RESET] && EVT_I.bus_off;
    if (next_st.pm_reset)
    begin
      next_st.tx_error_count = RST_ERR_CNT;
      next_st.rx_error_count = RST_ERR_CNT;
    end
    // configuration writes land only in init mode
    // outside init the write is dropped silently, with no error to the cpu
    if (wr_bufcnt && EVT_I.init_state)
    begin
      next_st.base_sel = BASE_AREA_ONLY;
      next_st.buf_count = fix_count(wd[BIT_CNT_TOP:0], st.buf_count);
    end
    // registered read data; unmapped addresses read zero
    next_st.rdata = RST_ERR_CNT;
    if (SFR_REQ_I.rd)
    begin
      unique case (SFR_REQ_I.addr)
        ADDR_ERR_STATUS: next_st.rdata = status_view;
        ADDR_TX_ERR_CNT: next_st.rdata = st.tx_error_count;
        ADDR_RX_ERR_CNT: next_st.rdata = st.rx_error_count;
        ADDR_BUF_COUNT: next_st.rdata = {st.base_sel, 1'b0, st.buf_count};
        default: next_st.rdata = RST_ERR_CNT;
      endcase
    end
  end

  // state register; count field resets to zero at base area 11
  // software must write a legal count in init mode before receiving
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      st <= '0;
      st.base_sel <= RST_BUF_COUNT[BIT_BASE_HI:BIT_BASE_LO];
      st.buf_count <= RST_BUF_COUNT[BIT_CNT_TOP:0];
      st.tx_error_count <= RST_ERR_CNT;
      st.rx_error_count <= RST_ERR_CNT;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs come straight from the state flops
  // no logic after the flops, so the pins never glitch
  assign SFR_RDATA_O = st.rdata;
  assign ERR_INT_O = st.err_int;
  assign TX_KEEP_REQ_O = st.tx_keep_req;
  assign RX_FLAGS_BLOCK_O = st.rx_flags_block;
  assign RX_DISCARD_O = st.rx_discard;
  assign PM_RESET_O = st.pm_reset;
  assign BASE_SEL_O = st.base_sel;
  assign BUF_COUNT_O = st.buf_count;

endmodule : ces_core

// file: inc/ces_pkg.sv
// package for the can error status and receive buffer count block
package ces_pkg;
  // sfr addresses
  localparam logic [15:0] ADDR_ERR_STATUS = 16'hffb4;
  localparam logic [15:0] ADDR_TX_ERR_CNT = 16'hffb5;
  localparam logic [15:0] ADDR_RX_ERR_CNT = 16'hffb6;
  localparam logic [15:0] ADDR_BUF_COUNT = 16'hffb7;
  // reset values
  localparam logic [7:0] RST_ERR_STATUS = 8'h00;
  localparam logic [7:0] RST_ERR_CNT = 8'h00;
  localparam logic [7:0] RST_BUF_COUNT = 8'hc0;
  // error status field positions
  localparam int BIT_OVER = 0;
  localparam int BIT_WAKE = 1;
  localparam int BIT_VALID = 2;
  localparam int BIT_INIT_STATE = 3;
  localparam int BIT_TECS = 5;
  localparam int BIT_RECS = 6;
  localparam int BIT_BOFF = 7;
  // buffer count register field positions
  localparam int BIT_BASE_HI = 7;
  localparam int BIT_BASE_LO = 6;
  localparam int BIT_PM_RESET = 5;
  localparam int BIT_CNT_TOP = 4;
  // field values
  localparam logic [1:0] BASE_AREA_ONLY = 2'h3;
  localparam logic [4:0] BUF_COUNT_MAX = 5'h10;
  localparam logic [4:0] BUF_COUNT_ZERO = 5'h00;
  // error counter thresholds and steps
  localparam logic [7:0] ERR_WARN_LEVEL = 8'h60;
  localparam logic [7:0] ERR_STEP_BIG = 8'h08;
  localparam logic [7:0] ERR_STEP_ONE = 8'h01;
  localparam logic [7:0] ERR_SAT = 8'hff;
  localparam logic [7:0] REC_PASSIVE_TOP = 8'h7f;

  // sfr access from the cpu side
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ces_sfr_req_t;

  // events from the protocol machine and mode controller
  typedef struct packed {
    logic valid_frame;
    logic bus_activity;
    logic sleep_state;
    logic sleep_req;
    logic rx_tx_busy;
    logic init_req;
    logic init_state;
    logic bus_off;
    logic tx_fetch_miss;
    logic rx_store_miss;
    logic id_fetch_miss;
    logic tx_err;
    logic tx_ok;
    logic rx_err;
    logic rx_err_primary;
    logic rx_ok;
  } ces_evt_t;

  // whole state of the block
  typedef struct packed {
    logic valid;
    logic wake;
    logic over;
    logic [7:0] tx_error_count;
    logic [7:0] rx_error_count;
    logic [1:0] base_sel;
    logic [4:0] buf_count;
    logic [7:0] rdata;
    logic err_int;
    logic tx_keep_req;
    logic rx_flags_block;
    logic rx_discard;
    logic pm_reset;
  } ces_state_t;
endpackage : ces_pkg

// file: testbench/ces_core_bench.sv
// self-checking bench for the error status block
`timescale 1ns/1ns
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module ces_core_bench import ces_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic preq = 1'b0;
  logic [3:0] kind = 4'h0;
  ces_sfr_req_t req = '0;
  ces_evt_t lvl = '0;
  ces_evt_t far;
  logic [7:0] rdata;
  logic [7:0] tx_error_count = 8'h00;
  logic [7:0] rx_error_count = 8'h00;
  logic [4:0] ecnt = 5'h00;
  logic [4:0] cnt;
  logic [1:0] base;
  logic err_int, keep, blk, disc, pmr;
  logic [7:0] vals [4] = '{8'h00, 8'h1f, 8'h01, 8'h10};
  logic [31:0] seed = 32'ha28b_5890;
  int n_errors = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  ces_far_node FAR (.CLK_I(clk), .SYS_RST_I(rst), .req_i(preq), .kind_i(kind), .evt_o(far));
  ces_core DUT (.CLK_I(clk), .SYS_RST_I(rst), .SFR_REQ_I(req), .SFR_RDATA_O(rdata),
    .EVT_I(ces_evt_t'(far | lvl)), .ERR_INT_O(err_int), .TX_KEEP_REQ_O(keep),
    .RX_FLAGS_BLOCK_O(blk), .RX_DISCARD_O(disc), .PM_RESET_O(pmr), .BASE_SEL_O(base),
    .BUF_COUNT_O(cnt));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // expected counter steps, saturating at both ends
  function automatic void upd(input logic [3:0] k);
    case (k)
      4'hb: tx_error_count = (tx_error_count > 8'hf7) ? 8'hff : tx_error_count + 8'h08;
      4'hc: tx_error_count = (tx_error_count == 8'h00) ? 8'h00 : tx_error_count - 8'h01;
      4'hd: rx_error_count = (rx_error_count == 8'hff) ? 8'hff : rx_error_count + 8'h01;
      4'he: rx_error_count = (rx_error_count > 8'hf7) ? 8'hff : rx_error_count + 8'h08;
      default: rx_error_count = (rx_error_count > 8'h7f) ? 8'h7f : (rx_error_count == 8'h00) ? 8'h00 : rx_error_count - 8'h01;
    endcase
  endfunction : upd
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, 1'b1, 1'b0, d};
    @(posedge clk) req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge clk) req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk) req <= '0;
    #1 `CHK(n, e, rdata)
  endtask : rd
  // far node pulses one cycle later, the block answers a cycle after that
  task automatic ev(input logic [3:0] k);
    @(posedge clk) preq <= 1'b1;
    kind <= k;
    @(posedge clk) preq <= 1'b0;
    @(posedge clk) #1;
  endtask : ev
  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial
  begin
    logic [3:0] k;
    logic [7:0] d;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_TX_ERR_CNT, 8'h00, "tec");
    rd(ADDR_RX_ERR_CNT, 8'h00, "rec");
    rd(ADDR_BUF_COUNT, RST_BUF_COUNT, "cntreg");
    rd(16'hffb3, 8'h00, "unmapped");
    // wake while asleep; zero writes must not clear
    @(posedge clk) lvl.sleep_state <= 1'b1;
    ev(4'h1);
    `CHK("int", 1'b1, err_int)
    @(posedge clk) lvl <= '0;
    wr(ADDR_ERR_STATUS, 8'h00);
    `CHK("int", 1'b1, err_int)
    rd(ADDR_ERR_STATUS, 8'h02, "status");
    wr(ADDR_ERR_STATUS, 8'h02);
    `CHK("int", 1'b0, err_int)
    // sleep request while busy, then cleared by the hold request
    @(posedge clk) lvl.rx_tx_busy <= 1'b1;
    ev(4'h3);
    `CHK("int", 1'b1, err_int)
    @(posedge clk) lvl <= 16'h0400;
    @(posedge clk) lvl <= '0;
    #1 `CHK("int", 1'b0, err_int)
    // good frame; a clear in the setting cycle loses
    @(posedge clk) preq <= 1'b1;
    kind <= 4'h0;
    @(posedge clk) preq <= 1'b0;
    req <= '{ADDR_ERR_STATUS, 1'b1, 1'b0, 8'h04};
    wr(ADDR_ERR_STATUS, 8'h00);
    rd(ADDR_ERR_STATUS, 8'h04, "status");
    wr(ADDR_ERR_STATUS, 8'h04);
    rd(ADDR_ERR_STATUS, 8'h00, "status");
    for (int i = 8; i < 11; i++)
    begin
      ev(4'(i));
      `CHK("miss", {i == 8, i == 9, i == 10}, {keep, blk, disc})
      rd(ADDR_ERR_STATUS, 8'h01, "status");
      wr(ADDR_ERR_STATUS, 8'h01);
    end
    repeat (100)
    begin
      k = 4'(4'hb + xs() % 5);
      ev(k);
      upd(k);
    end
    rd(ADDR_TX_ERR_CNT, tx_error_count, "tec");
    rd(ADDR_RX_ERR_CNT, rx_error_count, "rec");
    rd(ADDR_ERR_STATUS, {1'b0, rx_error_count >= ERR_WARN_LEVEL, tx_error_count >= ERR_WARN_LEVEL, 5'h00},
       "status");
    // count writes in init mode: corners first, then random
    @(posedge clk) lvl.init_state <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      d = (i < 4) ? vals[i] : 8'(xs());
      wr(ADDR_BUF_COUNT, d);
      ecnt = d[4] ? BUF_COUNT_MAX : (d[4:0] == 5'h00) ? ecnt : d[4:0];
      `CHK("count", ecnt, cnt)
      rd(ADDR_BUF_COUNT, {BASE_AREA_ONLY, 1'b0, ecnt}, "cntreg");
    end
    @(posedge clk) lvl <= '0;
    wr(ADDR_BUF_COUNT, {3'h0, ~ecnt});
    `CHK("count", ecnt, cnt)
    wr(ADDR_BUF_COUNT, 8'h20);
    `CHK("pm", 1'b0, pmr)
    // make sure the counters are not already zero before the protocol reset
    ev(4'hb);
    ev(4'hd);
    @(posedge clk) lvl.bus_off <= 1'b1;
    wr(ADDR_BUF_COUNT, 8'h20);
    `CHK("pm", 1'b1, pmr)
    @(posedge clk) lvl <= '0;
    rd(ADDR_TX_ERR_CNT, 8'h00, "tec");
    rd(ADDR_RX_ERR_CNT, 8'h00, "rec");
    `CHK("base", BASE_AREA_ONLY, base)
    // mid-run reset with a raised counter and a standing overrun
    ev(4'hb);
    ev(4'h8);
    `CHK("int", 1'b1, err_int)
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 `CHK("int", 1'b0, err_int)
    rd(ADDR_TX_ERR_CNT, 8'h00, "tec");
    rd(ADDR_BUF_COUNT, RST_BUF_COUNT, "cntreg");
    results();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule : ces_core_bench

// file: testbench/ces_core_sva.sv
// checker on the ports of the error status block
`timescale 1ns/1ns
module ces_core_sva
  import ces_pkg::*;
(
  // clock and inputs
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire ces_sfr_req_t SFR_REQ_I,
  input wire ces_evt_t EVT_I,
  // outputs
  input wire logic ERR_INT_O,
  input wire logic TX_KEEP_REQ_O,
  input wire logic RX_DISCARD_O,
  input wire logic PM_RESET_O,
  input wire logic [4:0] BUF_COUNT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // only a status write or a hold request may drop the interrupt
  wire logic sw = SFR_REQ_I.wr && SFR_REQ_I.addr == ADDR_ERR_STATUS;
  wire logic cw = SFR_REQ_I.wr && SFR_REQ_I.addr == ADDR_BUF_COUNT;
  wire ces_evt_t e = EVT_I;
  wire logic miss = e.tx_fetch_miss || e.rx_store_miss || e.id_fetch_miss;
  wake_int_a: assert property (e.sleep_state && e.bus_activity |=> ERR_INT_O)
    else $error("wake");
  busy_int_a: assert property (e.sleep_req && e.rx_tx_busy |=> ERR_INT_O)
    else $error("busy");
  int_hold_a: assert property (ERR_INT_O && !sw && !e.init_req |=> ERR_INT_O)
    else $error("hold");
  over_int_a: assert property (miss |=> ERR_INT_O)
    else $error("over");
  keep_req_a: assert property (e.tx_fetch_miss |=> TX_KEEP_REQ_O)
    else $error("keep");
  drop_msg_a: assert property (e.id_fetch_miss ##1 !e.id_fetch_miss |-> RX_DISCARD_O ##1 !RX_DISCARD_O)
    else $error("drop");
  cnt_hold_a: assert property (cw && !e.init_state |=> $stable(BUF_COUNT_O))
    else $error("count");
  pm_cause_a: assert property (PM_RESET_O |-> $past(e.bus_off) && $past(cw)
    && $past(SFR_REQ_I.wdata[BIT_PM_RESET]))
    else $error("pm");
  cover property (ERR_INT_O ##1 !ERR_INT_O);
  cover property (PM_RESET_O);
  cover property (cw && e.init_state);
endmodule : ces_core_sva
bind ces_core ces_core_sva u_sva (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .SFR_REQ_I(SFR_REQ_I),
  .EVT_I(EVT_I), .ERR_INT_O(ERR_INT_O), .TX_KEEP_REQ_O(TX_KEEP_REQ_O),
  .RX_DISCARD_O(RX_DISCARD_O), .PM_RESET_O(PM_RESET_O), .BUF_COUNT_O(BUF_COUNT_O));

// file: testbench/ces_far_node.sv
// far node model: one bus event pulse per request
`timescale 1ns/1ns
module ces_far_node
  import ces_pkg::*;
(
  // clock, reset, request
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic req_i,
  input wire logic [3:0] kind_i,
  // event out
  output ces_evt_t evt_o
);
  // single pulses keep the bus slow next to the clock
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
    if (SYS_RST_I)
      evt_o <= '0;
    else
      evt_o <= req_i ? ces_evt_t'(16'h8000 >> kind_i) : '0;
endmodule : ces_far_node
